// file: logic/ctt_pkg.sv
// Constants and carrier types for the instruction timing unit
package ctt_pkg;
    // Field widths
    localparam int LEN_W = 2;
    localparam int CYC_W = 4;
    localparam int STR_W = 4;
    localparam int OP_W = 8;
    // Program bytes per instruction
    localparam logic [LEN_W-1:0] LEN_1 = 2'h1;
    localparam logic [LEN_W-1:0] LEN_2 = 2'h2;
    localparam logic [LEN_W-1:0] LEN_3 = 2'h3;
    // Core clock cycles per instruction
    localparam logic [CYC_W-1:0] CYC_1 = 4'h1;
    localparam logic [CYC_W-1:0] CYC_2 = 4'h2;
    localparam logic [CYC_W-1:0] CYC_3 = 4'h3;
    localparam logic [CYC_W-1:0] CYC_4 = 4'h4;
    localparam logic [CYC_W-1:0] CYC_XRAM_MIN = 4'h3;
    localparam logic [CYC_W-1:0] CYC_XRAM_MAX = 4'hc;
    localparam logic [STR_W-1:0] STRETCH_MAX =
        STR_W'(CYC_XRAM_MAX - CYC_XRAM_MIN);
    // Values after reset
    localparam logic [CYC_W-1:0] CNT_RST = 4'h0;
    localparam logic [OP_W-1:0] OP_RST = 8'h00;

    // Decoded length and duration of one instruction
    typedef struct packed {
        logic known;
        logic xram;
        logic [LEN_W-1:0] len;
        logic [CYC_W-1:0] cyc;
    } ctt_dec_t;

    // Cycle counter state
    typedef struct packed {
        logic [CYC_W-1:0] cnt;
        logic busy;
        logic last;
        logic free;
    } ctt_cnt_t;

    // Top-level state
    typedef struct packed {
        logic [OP_W-1:0] op;
        ctt_dec_t dec;
    } ctt_top_t;
endpackage

// file: logic/ctt_xram_cycles.sv
// Duration of an auxiliary or external RAM access
`timescale 1ns/10ps
module ctt_xram_cycles (
    // Access target and stretch setting
    input wire logic ext_sel,
    input wire logic [ctt_pkg::STR_W-1:0] stretch,
    // Resulting cycle count
    output logic [ctt_pkg::CYC_W-1:0] cyc
);
    import ctt_pkg::*;

    // Stretch settings past the top clamp, so a bad value cannot wrap
    always_comb begin
        if (!ext_sel) begin
            cyc = CYC_XRAM_MIN;
        end else if (stretch > STRETCH_MAX) begin
            cyc = CYC_XRAM_MAX;
        end else begin
            cyc = CYC_W'(CYC_XRAM_MIN + stretch);
        end
    end
endmodule

// file: logic/ctt_cycle_counter.sv
// Down counter that holds an instruction for its cycle count
`timescale 1ns/10ps
module ctt_cycle_counter (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Load request
    input wire logic load,
    input wire logic [ctt_pkg::CYC_W-1:0] load_cyc,
    // Status
    output logic busy,
    output logic last,
    output logic free
);
    import ctt_pkg::*;

    ctt_cnt_t st;
    ctt_cnt_t next_st;

    // Free is high in the last cycle too, so loads run back to back
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.cnt = load_cyc;
            next_st.busy = 1'b1;
            next_st.last = (load_cyc == CYC_1);
            next_st.free = (load_cyc == CYC_1);
        end else if (st.busy) begin
            next_st.cnt = st.cnt - CYC_1;
            next_st.busy = (st.cnt != CYC_1);
            next_st.last = (st.cnt == CYC_2);
            next_st.free = (st.cnt == CYC_2) || (st.cnt == CYC_1);
        end else begin
            next_st.last = 1'b0;
            next_st.free = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '{cnt: CNT_RST, busy: 1'b0, last: 1'b0, free: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign busy = st.busy;
    assign last = st.last;
    assign free = st.free;
endmodule

// file: logic/ctt_timing_unit.sv
// Length and cycle timing for transfer and add/subtract instructions
`timescale 1ns/10ps

module ctt_timing_unit (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Opcode from fetch
    input wire logic op_valid,
    input wire logic [ctt_pkg::OP_W-1:0] op_byte,
    output logic op_ready,
    // Auxiliary RAM target and stretch
    input wire logic ext_sel,
    input wire logic [ctt_pkg::STR_W-1:0] stretch,
    // Decoded instruction
    output logic [ctt_pkg::OP_W-1:0] instr_op,
    output logic [ctt_pkg::LEN_W-1:0] instr_len,
    output logic [ctt_pkg::CYC_W-1:0] instr_cycles,
    output logic instr_known,
    output logic instr_xram,
    // Execution progress
    output logic exec_busy,
    output logic exec_last
);
    import ctt_pkg::*;

    ctt_top_t st;
    ctt_top_t next_st;
    ctt_dec_t dec;
    logic accept;
    logic [CYC_W-1:0] xram_cyc;

    // Stretch is sampled with the opcode, never mid-instruction
    ctt_xram_cycles u_xram (
        .ext_sel(ext_sel),
        .stretch(stretch),
        .cyc(xram_cyc)
    );

    assign accept = op_valid && op_ready;

    // Opcode table; codes outside this group still run, flagged unknown
    always_comb begin
        next_st = st;
        dec = '{known: 1'b1, xram: 1'b0, len: LEN_1, cyc: CYC_1};
        casez (op_byte)
            8'b1110_1???: begin // Register to accumulator
                dec.cyc = CYC_2;
            end
            8'he5: begin // Direct byte to accumulator
                dec.len = LEN_2;
                dec.cyc = CYC_2;
            end
            8'b1110_011?: begin // Pointer RAM to accumulator
                dec.cyc = CYC_2;
            end
            8'h74: begin // Immediate to accumulator
                dec.len = LEN_2;
                dec.cyc = CYC_2;
            end
            8'b1111_1???: begin // Accumulator to register
                dec.cyc = CYC_2;
            end
            8'b1010_1???: begin // Direct byte to register
                dec.len = LEN_2;
                dec.cyc = CYC_4;
            end
            8'b0111_1???: begin // Immediate to register
                dec.len = LEN_2;
                dec.cyc = CYC_2;
            end
            8'hf5, 8'b1000_1???: begin // Acc or register to direct
                dec.len = LEN_2;
                dec.cyc = CYC_3;
            end
            8'h85: begin // Direct to direct
                dec.len = LEN_3;
                dec.cyc = CYC_4;
            end
            8'b1000_011?: begin // Pointer RAM to direct
                dec.len = LEN_2;
                dec.cyc = CYC_4;
            end
            8'h75: begin // Immediate to direct
                dec.len = LEN_3;
                dec.cyc = CYC_3;
            end
            8'b1111_011?: begin // Accumulator to pointer RAM
                dec.cyc = CYC_3;
            end
            8'b1010_011?, 8'b0111_011?: begin // Direct/imm to pointer RAM
                dec.len = LEN_2;
                dec.cyc = CYC_3;
            end
            8'h90: begin // Load data pointer
                dec.len = LEN_3;
                dec.cyc = CYC_3;
            end
            8'h93, 8'h83: begin // Code table reads
                dec.cyc = CYC_4;
            end
            8'he0, 8'b1110_001?, 8'hf0, 8'b1111_001?: begin
                // Auxiliary RAM, both directions, both widths
                dec.xram = 1'b1;
                dec.cyc = xram_cyc;
            end
            8'hc0: begin // Push
                dec.len = LEN_2;
                dec.cyc = CYC_4;
            end
            8'hd0: begin // Pop
                dec.len = LEN_2;
                dec.cyc = CYC_3;
            end
            8'b1100_1???: begin // Exchange with register
                dec.cyc = CYC_3;
            end
            8'hc5: begin // Exchange with direct
                dec.len = LEN_2;
                dec.cyc = CYC_4;
            end
            8'b1100_011?: begin // Exchange with pointer RAM
                dec.cyc = CYC_4;
            end
            8'b1101_011?: begin // Low nibble exchange
                dec.cyc = CYC_4;
            end
            8'b0010_1???, 8'b0011_1???, 8'b1001_1???: begin
                // Add, add with carry, subtract: register operand
                dec.cyc = CYC_2;
            end
            8'h24, 8'h34, 8'h94: begin // Immediate operand forms
                dec.len = LEN_2;
                dec.cyc = CYC_2;
            end
            8'h25, 8'h35, 8'h95: begin // Direct operand forms
                dec.len = LEN_2;
                dec.cyc = CYC_3;
            end
            8'b0010_011?, 8'b0011_011?, 8'b1001_011?: begin
                // Pointer RAM operand forms
                dec.cyc = CYC_3;
            end
            default: begin
                dec.known = 1'b0;
            end
        endcase
        if (accept) begin
            next_st.op = op_byte;
            next_st.dec = dec;
        end
    end

    // Decoded fields are held until the next opcode is taken
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '{op: OP_RST,
                    dec: '{known: 1'b0, xram: 1'b0,
                           len: LEN_1, cyc: CYC_1}};
        end else begin
            st <= next_st;
        end
    end

    // Counter holds each instruction for exactly its cycle count
    ctt_cycle_counter u_cnt (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(accept),
        .load_cyc(dec.cyc),
        .busy(exec_busy),
        .last(exec_last),
        .free(op_ready)
    );

    assign instr_op = st.op;
    assign instr_len = st.dec.len;
    assign instr_cycles = st.dec.cyc;
    assign instr_known = st.dec.known;
    assign instr_xram = st.dec.xram;

    // Checks on decode and timing
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_acc_from_reg:
    assert property (accept && op_byte ==? 8'b1110_1??? |=>
        instr_len == LEN_1 && instr_cycles == CYC_2 && instr_known)
    else $error("register to accumulator timing wrong");

    a_acc_from_ptr:
    assert property (accept && op_byte ==? 8'b1110_011? |=>
        exec_busy && !exec_last && !op_ready ##1 exec_last && op_ready)
    else $error("pointer load did not take two cycles");

    a_acc_from_imm:
    assert property (accept && op_byte == 8'h74 |=>
        instr_len == LEN_2 && instr_cycles == CYC_2)
    else $error("immediate load timing wrong");

    a_reg_from_dir:
    assert property (accept && op_byte ==? 8'b1010_1??? |=>
        !exec_last [*3] ##1 exec_last)
    else $error("direct to register did not take four cycles");

    a_reg_from_imm:
    assert property (accept && op_byte ==? 8'b0111_1??? |=>
        instr_len == LEN_2 && instr_cycles == CYC_2)
    else $error("immediate to register timing wrong");

    a_store_direct:
    assert property (accept && op_byte == 8'hf5 |=>
        !op_ready ##1 !op_ready ##1 op_ready && exec_last)
    else $error("store to direct did not take three cycles");

    a_dir_to_dir:
    assert property (accept && op_byte == 8'h85 |=>
        instr_len == LEN_3 && exec_busy [*4])
    else $error("direct to direct timing wrong");

    a_imm_to_dir:
    assert property (accept && op_byte == 8'h75 |=>
        instr_len == LEN_3 && instr_cycles == CYC_3)
    else $error("immediate to direct timing wrong");

    a_ptr_store:
    assert property (accept && op_byte ==? 8'b1111_011? |=>
        instr_len == LEN_1 && instr_cycles == CYC_3)
    else $error("accumulator to pointer RAM timing wrong");

    a_code_read:
    assert property (accept && (op_byte == 8'h93 || op_byte == 8'h83)
        |=> instr_cycles == CYC_4 ##3 exec_last)
    else $error("code table read timing wrong");

    a_xram_onchip:
    assert property (accept && op_byte == 8'he0 && !ext_sel |=>
        instr_xram && instr_cycles == CYC_XRAM_MIN)
    else $error("on-chip auxiliary access not three cycles");

    a_xram_stretch:
    assert property (accept && op_byte == 8'hf0 && ext_sel |=>
        instr_cycles >= CYC_XRAM_MIN && instr_cycles <= CYC_XRAM_MAX
        && instr_cycles == CYC_W'(CYC_XRAM_MIN +
           (($past(stretch) > STRETCH_MAX) ? STRETCH_MAX
                                           : $past(stretch))))
    else $error("external access does not follow stretch");

    a_push_pop:
    assert property (accept && (op_byte == 8'hc0 || op_byte == 8'hd0)
        |=> instr_len == LEN_2 &&
            instr_cycles == ((instr_op == 8'hc0) ? CYC_4 : CYC_3))
    else $error("push or pop timing wrong");

    a_xchg_reg:
    assert property (accept && op_byte ==? 8'b1100_1??? |=>
        instr_len == LEN_1 && instr_cycles == CYC_3)
    else $error("register exchange timing wrong");

    a_nibble_xchg:
    assert property (accept && op_byte ==? 8'b1101_011? |=>
        instr_len == LEN_1 && instr_cycles == CYC_4)
    else $error("nibble exchange timing wrong");

    a_arith_direct:
    assert property (accept && (op_byte == 8'h25 || op_byte == 8'h35
        || op_byte == 8'h95) |=> instr_len == LEN_2 &&
        instr_cycles == CYC_3)
    else $error("direct operand arithmetic timing wrong");

    a_arith_reg:
    assert property (accept && (op_byte ==? 8'b0011_1???
        || op_byte ==? 8'b1001_1???) |=> instr_cycles == CYC_2)
    else $error("register operand arithmetic timing wrong");

    a_acc_to_reg:
    assert property (accept && op_byte ==? 8'b1111_1??? |=>
        instr_len == LEN_1 && instr_cycles == CYC_2)
    else $error("accumulator to register timing wrong");

    a_reg_to_dir:
    assert property (accept && op_byte ==? 8'b1000_1??? |=>
        !exec_last ##1 !exec_last ##1 exec_last && instr_len == LEN_2)
    else $error("register to direct did not take three cycles");

    a_ptr_to_dir:
    assert property (accept && op_byte ==? 8'b1000_011? |=>
        instr_len == LEN_2 && instr_cycles == CYC_4)
    else $error("pointer to direct timing wrong");

    a_ptr_store_src:
    assert property (accept && (op_byte ==? 8'b1010_011?
        || op_byte ==? 8'b0111_011?) |=>
        instr_len == LEN_2 && instr_cycles == CYC_3)
    else $error("direct or immediate to pointer RAM timing wrong");

    a_load_pointer:
    assert property (accept && op_byte == 8'h90 |=>
        instr_len == LEN_3 && !exec_last ##1 !exec_last ##1 exec_last)
    else $error("data pointer load timing wrong");

    a_xram_width:
    assert property (accept && !ext_sel && (op_byte ==? 8'b111?_001?
        || op_byte ==? 8'b111?_0000) |=> instr_xram &&
        instr_len == LEN_1 && instr_cycles == CYC_XRAM_MIN)
    else $error("on-chip auxiliary access timing wrong");

    a_xram_longest:
    assert property (accept && ext_sel && stretch >= STRETCH_MAX &&
        (op_byte ==? 8'b111?_001? || op_byte ==? 8'b111?_0000) |=>
        !exec_last [*8] ##1 !exec_last [*3] ##1 exec_last)
    else $error("longest external access not twelve cycles");

    a_pop_cycles:
    assert property (accept && op_byte == 8'hd0 |=>
        !exec_last ##1 !exec_last ##1 exec_last)
    else $error("pop did not take three cycles");

    a_xchg_dir:
    assert property (accept && op_byte == 8'hc5 |=>
        instr_len == LEN_2 && instr_cycles == CYC_4)
    else $error("direct exchange timing wrong");

    a_add_imm:
    assert property (accept && (op_byte == 8'h24 || op_byte == 8'h34)
        |=> instr_len == LEN_2 && instr_cycles == CYC_2)
    else $error("immediate add timing wrong");

    a_subb_ptr:
    assert property (accept && op_byte ==? 8'b1001_011? |=>
        instr_len == LEN_1 && instr_cycles == CYC_3)
    else $error("pointer subtract timing wrong");

    a_busy_match:
    assert property (accept |=> exec_busy &&
        exec_last == (instr_cycles == CYC_1) &&
        op_ready == (instr_cycles == CYC_1))
    else $error("busy start does not match cycle count");
endmodule

// file: tb/ctt_prog_mem.sv
// Program memory model that offers opcode bytes to the timing unit
`timescale 1ns/10ps
module ctt_prog_mem (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Flow control from the bench
    input wire logic stall,
    input wire logic [8:0] plen,
    // Opcode offer
    input wire logic op_ready,
    output logic op_valid,
    output logic [7:0] op_byte,
    output logic [8:0] pc
);
    logic [7:0] prog [0:511];
    logic [7:0] fill;

    // Bench fills the program before reset is released
    task automatic put(input int a, input logic [7:0] d);
        prog[a] = d;
    endtask

    // An offer stands until taken; a stall only delays a fresh offer
    always @(posedge ref_clk) begin
        if (rst) begin
            pc <= 9'h000;
            op_valid <= 1'b0;
            fill <= 8'h5a;
        end else begin
            fill <= fill + 8'h3b;
            if (op_valid && op_ready) begin
                pc <= pc + 9'h001;
                op_valid <= !stall && (pc + 9'h001 != plen);
            end else if (!op_valid) begin
                op_valid <= !stall && (pc != plen);
            end
        end
    end

    // Idle bus shows a changing pattern, never a stale opcode
    assign op_byte = op_valid ? prog[pc] : fill;
endmodule

// file: tb/tb.sv
// Self-checking bench for the instruction timing unit
`timescale 1ns/10ps
module tb;
    import ctt_pkg::*;
    logic ref_clk, rst, stall, ext_sel, op_valid, op_ready;
    logic [3:0] stretch;
    logic [7:0] op_byte, instr_op, eop;
    logic [8:0] plen, pc;
    logic [1:0] instr_len;
    logic [3:0] instr_cycles;
    logic instr_known, instr_xram, exec_busy, exec_last;
    logic [31:0] rnd;
    int num_errors, checks, left;
    bit first, done;
    ctt_dec_t e;

    ctt_timing_unit u_dut (.ref_clk(ref_clk), .rst(rst),
        .op_valid(op_valid), .op_byte(op_byte), .op_ready(op_ready),
        .ext_sel(ext_sel), .stretch(stretch), .instr_op(instr_op),
        .instr_len(instr_len), .instr_cycles(instr_cycles),
        .instr_known(instr_known), .instr_xram(instr_xram),
        .exec_busy(exec_busy), .exec_last(exec_last));
    ctt_prog_mem u_mem (.ref_clk(ref_clk), .rst(rst), .stall(stall),
        .plen(plen), .op_ready(op_ready), .op_valid(op_valid),
        .op_byte(op_byte), .pc(pc));

    // Clock at 40 MHz
    always #12.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    function automatic ctt_dec_t mk(input logic [1:0] l, input logic [3:0] c);
        return '{known: 1'b1, xram: 1'b0, len: l, cyc: c};
    endfunction

    // Expected length and duration, classic public encoding
    function automatic ctt_dec_t exp_dec(input logic [7:0] op,
            input logic ext, input logic [3:0] str);
        ctt_dec_t d;
        d = '{known: 1'b0, xram: 1'b0, len: LEN_1, cyc: CYC_1};
        casez (op)
            8'b1110_1???: d = mk(LEN_1, CYC_2);
            8'he5: d = mk(LEN_2, CYC_2);
            8'he6, 8'he7: d = mk(LEN_1, CYC_2);
            8'h74: d = mk(LEN_2, CYC_2);
            8'b1111_1???: d = mk(LEN_1, CYC_2);
            8'b1010_1???: d = mk(LEN_2, CYC_4);
            8'b0111_1???: d = mk(LEN_2, CYC_2);
            8'hf5, 8'b1000_1???: d = mk(LEN_2, CYC_3);
            8'h85: d = mk(LEN_3, CYC_4);
            8'h86, 8'h87: d = mk(LEN_2, CYC_4);
            8'h75: d = mk(LEN_3, CYC_3);
            8'hf6, 8'hf7: d = mk(LEN_1, CYC_3);
            8'ha6, 8'ha7, 8'h76, 8'h77: d = mk(LEN_2, CYC_3);
            8'h90: d = mk(LEN_3, CYC_3);
            8'h93, 8'h83: d = mk(LEN_1, CYC_4);
            8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin
                d = mk(LEN_1, CYC_3);
                d.xram = 1'b1;
                if (ext) begin
                    d.cyc = (str > 4'h9) ? CYC_XRAM_MAX
                                         : CYC_XRAM_MIN + str;
                end
            end
            8'hc0: d = mk(LEN_2, CYC_4);
            8'hd0: d = mk(LEN_2, CYC_3);
            8'b1100_1???: d = mk(LEN_1, CYC_3);
            8'hc5: d = mk(LEN_2, CYC_4);
            8'hc6, 8'hc7: d = mk(LEN_1, CYC_4);
            8'hd6, 8'hd7: d = mk(LEN_1, CYC_4);
            8'b0010_1???, 8'b0011_1???, 8'b1001_1???:
                d = mk(LEN_1, CYC_2);
            8'h25, 8'h35, 8'h95:
                d = mk(LEN_2, CYC_3);
            8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97:
                d = mk(LEN_1, CYC_3);
            8'h24, 8'h34, 8'h94: d = mk(LEN_2, CYC_2);
            default: d.known = 1'b0;
        endcase
        return d;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
            input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Monitor: pre-edge values are the cycle that just ended
    always @(posedge ref_clk) begin
        if (rst) begin
            left = 0;
        end else begin
            if (left != 0) begin
                if (first) begin
                    check({8'h00, instr_op}, {8'h00, eop}, "op");
                    check({14'h0, instr_len}, {14'h0, e.len},
                          "len");
                    check({12'h0, instr_cycles}, {12'h0, e.cyc},
                          "cyc");
                    check({14'h0, instr_known, instr_xram},
                          {14'h0, e.known, e.xram}, "kind");
                end
                first = 0;
                check({15'h0, exec_busy}, 16'h0001, "busy");
                check({14'h0, exec_last, op_ready},
                      {14'h0, left == 1, left == 1}, "last");
                left--;
            end else begin
                check({13'h0, exec_busy, exec_last, op_ready},
                      16'h0001, "idle");
            end
            // Offer taken at this edge: the next cycles belong to it
            if (op_valid && op_ready) begin
                e = exp_dec(op_byte, ext_sel, stretch);
                eop = op_byte;
                left = e.cyc;
                first = 1;
            end
        end
    end

    // Main sequence: every opcode back to back, then random ones with stalls
    initial begin
        ref_clk = 0;
        rst = 1;
        stall = 0;
        ext_sel = 0;
        stretch = 4'h0;
        num_errors = 0;
        checks = 0;
        left = 0;
        first = 0;
        done = 0;
        rnd = 32'h0000102f;
        for (int i = 0; i < 511; i++) begin
            rnd = xs(rnd);
            u_mem.put(i, (i < 256) ? i[7:0] : rnd[7:0]);
        end
        plen = 9'h1ff;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check({instr_op, 2'h0, instr_len, instr_cycles},
              16'h0011, "reset out");
        check({14'h0, instr_known, instr_xram},
              16'h0000, "reset kind");
        for (int k = 0; k < 30000; k++) begin
            @(posedge ref_clk);
            rnd = xs(rnd);
            stretch <= rnd[3:0];
            ext_sel <= rnd[4];
            stall <= pc[8] && (rnd[7:6] == 2'h0);
            // A reset in mid-run restarts the program from the top
            rst <= (k >= 300 && k < 302);
            // Looked at mid-cycle, after the monitor has settled left
            @(negedge ref_clk);
            if (!rst && pc == plen && left == 0) begin
                done = 1;
                break;
            end
        end
        if (!done) begin
            num_errors++;
            $display("FAIL %0t program did not finish", $time);
        end
        end_sim();
    end
endmodule
